// file: rtl/acbd_pkg.sv
// Constants, types and register map of the ATA pass-through command block decoder.
// Assumes a 16-byte command block field handed over from a Bulk-Only wrapper parser.
// Contract
// - Select bits 0..7 map devctl through command
// - Byte 4 is block size in sectors
// - Legal counts powers of two; 0 means 256
// - Illegal block count reports command failed
// - Bytes 5..12 are taskfile write values
// - Second format rides in wrapper block field
// - Second format only on signature match
// - Second format carries 48-bit commands
// - Wrapper block field keeps Bulk-Only limits
// - Ascending access order; unselected reads 0x00
package acbd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_V1_SIG = 8'h04;
  localparam logic [7:0] ADDR_V2_SIG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TF_RD_LO = 8'h10;
  localparam logic [7:0] ADDR_TF_RD_HI = 8'h14;
  // Control fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Signature reset values are arbitrary
  localparam logic [15:0] V1_SIG_RESET = 16'h5A24;
  localparam logic [15:0] V2_SIG_RESET = 16'h5A25;
  // Status fields
  localparam int ST_FMT_LSB = 0;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_SECT_LSB = 4;
  localparam int ST_RSVD_BIT = 13;
  localparam int ST_CNT_LSB = 16;
  // Command block byte positions
  localparam int CB_BYTES = 16;
  localparam int CB_ACTION = 2;
  localparam int CB_REG_SEL = 3;
  localparam int CB_BLK_CNT = 4;
  localparam int CB_TF_WR_FIRST = 5;
  localparam int CB_RSVD_FIRST = 13;
  localparam int ACT_TF_READ_BIT = 0;
  localparam int SECTOR_BYTES = 512;
  localparam int ZERO_COUNT_SECTORS = 256;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TF_DEVCTL = 3'h0, TF_FEATURES = 3'h1, TF_SECT_CNT = 3'h2, TF_SECT_NUM = 3'h3,
    TF_CYL_LO = 3'h4, TF_CYL_HI = 3'h5, TF_DEVICE = 3'h6, TF_COMMAND = 3'h7
  } acbd_tf_reg_t;

  typedef enum logic [1:0] {
    FMT_OTHER = 2'h0, FMT_V1 = 2'h1, FMT_V2 = 2'h2
  } acbd_fmt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_ACCESS = 3'b010, ST_DONE = 3'b100
  } acbd_state_t;
endpackage

// file: rtl/acbd_decoder.sv
// Command block decoder with taskfile access sequencer and AXI4-Lite registers.
// Assumes one clock; command block, length and taskfile ack are synchronous to core_clk.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module acbd_decoder #(
  parameter int TF_REGS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cb_valid,
  output logic cb_ready,
  input wire logic [8*acbd_pkg::CB_BYTES-1:0] cb_bytes,
  input wire logic [4:0] cb_length,
  output logic dec_valid,
  output acbd_pkg::acbd_fmt_t dec_format,
  output logic dec_fail,
  output logic [8:0] dec_sectors,
  output logic [17:0] dec_max_bytes,
  output logic dec_ext48,
  output logic tf_req,
  output logic tf_write,
  output acbd_pkg::acbd_tf_reg_t tf_index,
  output logic [7:0] tf_wdata,
  input wire logic tf_ack,
  input wire logic [7:0] tf_rdata,
  output logic [63:0] tf_read_bytes
);
  import acbd_pkg::*;

  if (TF_REGS != 8) begin : g_bad_tf_regs
    $error("acbd_decoder serves exactly eight taskfile registers");
  end

  function automatic logic blk_legal(input logic [7:0] c);
    return (c & (c - 8'h01)) == 8'h00;
  endfunction

  function automatic logic [8:0] blk_sectors(input logic [7:0] c);
    return (c == 8'h00) ? 9'(ZERO_COUNT_SECTORS) : {1'b0, c};
  endfunction

  function automatic logic [2:0] lowest_bit(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) r = 3'(i);
    end
    return r;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i+:8] = d[8*i+:8];
    end
    return r;
  endfunction

  // Register state
  logic [31:0] ctrl;
  logic [15:0] v1_sig;
  logic [15:0] v2_sig;
  logic [7:0] blk_count;
  logic rsvd_nonzero;
  logic busy;

  // Decode of the offered block
  logic [15:0] cb_sig;
  logic is_v2;
  logic is_v1;
  logic len_ok;
  logic [7:0] cnt_byte;
  logic v1_fail;
  assign cb_sig = {cb_bytes[7:0], cb_bytes[15:8]};
  assign len_ok = (cb_length != 5'h00) && (cb_length <= 5'(CB_BYTES));
  assign is_v2 = (cb_sig == v2_sig);
  assign is_v1 = !is_v2 && (cb_sig == v1_sig);
  assign cnt_byte = cb_bytes[8*CB_BLK_CNT+:8];
  assign v1_fail = !blk_legal(cnt_byte) || !len_ok;

  // Sequencer
  acbd_state_t state;
  logic [7:0] pend;
  logic [63:0] wr_bytes;
  logic rd_mode;
  logic take;
  logic tf_done;
  logic [2:0] cur;
  assign take = cb_valid && cb_ready;
  assign tf_done = tf_req && tf_ack;
  assign cur = lowest_bit(pend);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      pend <= 8'h00;
      wr_bytes <= 64'h0;
      rd_mode <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take && is_v1 && !v1_fail && ctrl[CTRL_EN_BIT]) begin
            pend <= cb_bytes[8*CB_REG_SEL+:8];
            wr_bytes <= cb_bytes[8*CB_TF_WR_FIRST+:64];
            rd_mode <= cb_bytes[8*CB_ACTION+ACT_TF_READ_BIT];
            state <= (cb_bytes[8*CB_REG_SEL+:8] == 8'h00) ? ST_DONE : ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (tf_done) begin
            pend[cur] <= 1'b0;
            if ((pend & ~(8'h01 << cur)) == 8'h00) state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Taskfile request; one access at a time, ascending
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf_req <= 1'b0;
      tf_write <= 1'b0;
      tf_index <= TF_DEVCTL;
      tf_wdata <= 8'h00;
    end else if (state == ST_ACCESS && !tf_req && pend != 8'h00) begin
      tf_req <= 1'b1;
      tf_write <= !rd_mode;
      tf_index <= acbd_tf_reg_t'(cur);
      tf_wdata <= wr_bytes[8*cur+:8];
    end else if (tf_done) begin
      tf_req <= 1'b0;
    end
  end

  // Read data: unselected registers stay 0x00
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf_read_bytes <= 64'h0;
    end else if (take && is_v1 && !v1_fail && ctrl[CTRL_EN_BIT]) begin
      tf_read_bytes <= 64'h0;
    end else if (tf_done && !tf_write) begin
      tf_read_bytes[8*tf_index+:8] <= tf_rdata;
    end
  end

  // Decode result and block handshake
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cb_ready <= 1'b0;
      busy <= 1'b0;
      dec_valid <= 1'b0;
      dec_format <= FMT_OTHER;
      dec_fail <= 1'b0;
      dec_sectors <= 9'h000;
      dec_max_bytes <= 18'h00000;
      dec_ext48 <= 1'b0;
      rsvd_nonzero <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      cb_ready <= (state == ST_IDLE) && !take && !busy;
      if (take) begin
        busy <= 1'b1;
        dec_sectors <= blk_sectors(cnt_byte);
        dec_max_bytes <= 18'(blk_sectors(cnt_byte) * SECTOR_BYTES);
        rsvd_nonzero <= cb_bytes[8*CB_RSVD_FIRST+:24] != 24'h0;
        if (is_v2) begin
          // Block field carried whole to the 48-bit path
          dec_format <= FMT_V2;
          dec_ext48 <= 1'b1;
          dec_fail <= cb_length != 5'(CB_BYTES);
        end else if (is_v1) begin
          dec_format <= FMT_V1;
          dec_ext48 <= 1'b0;
          dec_fail <= v1_fail || !ctrl[CTRL_EN_BIT];
        end else begin
          dec_format <= FMT_OTHER;
          dec_ext48 <= 1'b0;
          dec_fail <= !len_ok;
        end
      end
      if (busy && state != ST_ACCESS && !take) begin
        if (state == ST_IDLE || state == ST_DONE) begin
          dec_valid <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end

  // Count of decoded blocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_count <= 8'h00;
    end else if (dec_valid) begin
      blk_count <= blk_count + 8'h01;
    end
  end

  // AXI4-Lite write channel
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      v1_sig <= V1_SIG_RESET;
      v2_sig <= V2_SIG_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        unique case (aw_addr)
          ADDR_CTRL: ctrl <= strb_merge(ctrl, w_data, w_strb) & CTRL_RESET;
          ADDR_V1_SIG: v1_sig <= 16'(strb_merge({16'h0, v1_sig}, w_data, w_strb));
          ADDR_V2_SIG: v2_sig <= 16'(strb_merge({16'h0, v2_sig}, w_data, w_strb));
          ADDR_STATUS, ADDR_TF_RD_LO, ADDR_TF_RD_HI: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[ST_FMT_LSB+:2] = dec_format;
    status_word[ST_FAIL_BIT] = dec_fail;
    status_word[ST_BUSY_BIT] = busy;
    status_word[ST_SECT_LSB+:9] = dec_sectors;
    status_word[ST_RSVD_BIT] = rsvd_nonzero;
    status_word[ST_CNT_LSB+:8] = blk_count;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_CTRL: s_axi_rdata <= ctrl;
          ADDR_V1_SIG: s_axi_rdata <= {16'h0, v1_sig};
          ADDR_V2_SIG: s_axi_rdata <= {16'h0, v2_sig};
          ADDR_STATUS: s_axi_rdata <= status_word;
          ADDR_TF_RD_LO: s_axi_rdata <= tf_read_bytes[31:0];
          ADDR_TF_RD_HI: s_axi_rdata <= tf_read_bytes[63:32];
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // acbd_decoder

// file: tb/acbd_decoder_sva.sv
// Checker of decoder port behaviour for command blocks and taskfile accesses.
// Assumes signature registers hold their reset values.
`timescale 1ns/10ps
module acbd_decoder_sva
  import acbd_pkg::*;
#(
  parameter int TF_REGS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cb_valid,
  input wire logic cb_ready,
  input wire logic [8*acbd_pkg::CB_BYTES-1:0] cb_bytes,
  input wire logic dec_valid,
  input wire acbd_pkg::acbd_fmt_t dec_format,
  input wire logic dec_fail,
  input wire logic [8:0] dec_sectors,
  input wire logic [17:0] dec_max_bytes,
  input wire logic dec_ext48,
  input wire logic tf_req,
  input wire logic tf_write,
  input wire acbd_pkg::acbd_tf_reg_t tf_index,
  input wire logic [7:0] tf_wdata,
  input wire logic tf_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [127:0] cb_q;
  logic [2:0] last_idx;
  logic have_last;
  wire take = cb_valid && cb_ready;
  wire is_v1 = cb_bytes[15:0] == {V1_SIG_RESET[7:0], V1_SIG_RESET[15:8]};
  wire is_v2 = cb_bytes[15:0] == {V2_SIG_RESET[7:0], V2_SIG_RESET[15:8]};
  // Block captured at take, last access index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cb_q <= '0;
      have_last <= 1'b0;
      last_idx <= 3'h0;
    end else if (take) begin
      cb_q <= cb_bytes;
      have_last <= 1'b0;
    end else if (tf_req && tf_ack) begin
      have_last <= 1'b1;
      last_idx <= tf_index;
    end
  end
  property p_max; dec_valid |-> dec_max_bytes == {dec_sectors, 9'h000}; endproperty
  a_max: assert property (p_max) else $error("max bytes");
  property p_sect; take && is_v1 |=> dec_sectors == ((cb_q[39:32] == 8'h00) ? 9'h100 : {1'b0, cb_q[39:32]}); endproperty
  a_sect: assert property (p_sect) else $error("sectors");
  property p_fail; take && is_v1 && cb_bytes[39:32] != 8'h00 && !$onehot(cb_bytes[39:32]) |=> dec_fail; endproperty
  a_fail: assert property (p_fail) else $error("illegal count");
  property p_wdata; tf_req && tf_write |-> tf_wdata == cb_q[8*(5+tf_index) +: 8]; endproperty
  a_wdata: assert property (p_wdata) else $error("write data");
  property p_sel; tf_req |-> cb_q[24+tf_index]; endproperty
  a_sel: assert property (p_sel) else $error("unselected access");
  property p_order; tf_req && have_last |-> 3'(tf_index) > last_idx; endproperty
  a_order: assert property (p_order) else $error("access order");
  property p_fmt2; take && is_v2 |=> dec_format == FMT_V2; endproperty
  a_fmt2: assert property (p_fmt2) else $error("second format");
  property p_fmt0; take && !is_v1 && !is_v2 |=> dec_format == FMT_OTHER; endproperty
  a_fmt0: assert property (p_fmt0) else $error("other format");
  property p_ext; dec_valid |-> dec_ext48 == (dec_format == FMT_V2); endproperty
  a_ext: assert property (p_ext) else $error("ext48");
  property p_hold; tf_req && !tf_ack |=> tf_req && $stable(tf_index) && $stable(tf_wdata); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
endmodule // acbd_decoder_sva

bind acbd_decoder acbd_decoder_sva #(.TF_REGS(TF_REGS)) u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .cb_valid(cb_valid), .cb_ready(cb_ready), .cb_bytes(cb_bytes), .dec_valid(dec_valid),
  .dec_format(dec_format), .dec_fail(dec_fail), .dec_sectors(dec_sectors), .dec_max_bytes(dec_max_bytes),
  .dec_ext48(dec_ext48), .tf_req(tf_req), .tf_write(tf_write), .tf_index(tf_index),
  .tf_wdata(tf_wdata), .tf_ack(tf_ack));

// file: tb/acbd_tf_model.sv
// Taskfile side model: acks requests promptly or after a wait.
// Assumes requests held until acked; read data per register index.
`timescale 1ns/10ps
module acbd_tf_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic tf_req,
  input wire logic tf_write,
  input wire acbd_pkg::acbd_tf_reg_t tf_index,
  output logic tf_ack,
  output logic [7:0] tf_rdata
);
  import acbd_pkg::*;
  logic [1:0] wait_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf_ack <= 1'b0;
      wait_cnt <= 2'h0;
      tf_rdata <= 8'h00;
    end else if (tf_req && !tf_ack && (!slow || wait_cnt == 2'h3)) begin
      tf_ack <= 1'b1;
      tf_rdata <= tf_write ? ~tf_rdata : (8'hA0 | 8'(tf_index));
    end else begin
      tf_ack <= 1'b0;
      wait_cnt <= (tf_req && !tf_ack) ? wait_cnt + 2'h1 : 2'h0;
      // Released bus: keeps toggling
      tf_rdata <= ~tf_rdata;
    end
  end
endmodule // acbd_tf_model

// file: tb/tb.sv
// Bench of the command block decoder: register bus, block and taskfile traffic.
// Assumes the partner model answers taskfile accesses.
`timescale 1ns/10ps
module tb;
  import acbd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tf_wdata, tf_rdata, cnt;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, cb_valid = 1'b0, slow = 1'b0, tf_ack;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cb_ready;
  logic dec_valid, dec_fail, dec_ext48, tf_req, tf_write;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [127:0] cb_bytes = 128'h0, b;
  logic [4:0] cb_length = 5'h10;
  logic [8:0] dec_sectors;
  logic [17:0] dec_max_bytes;
  logic [63:0] tf_read_bytes, exp;
  acbd_fmt_t dec_format;
  acbd_tf_reg_t tf_index;
  int err_count = 0, n_compared = 0, cycles = 0;
  always #4 core_clk = ~core_clk;
  acbd_decoder dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cb_valid(cb_valid),
    .cb_ready(cb_ready),
    .cb_bytes(cb_bytes),
    .cb_length(cb_length),
    .dec_valid(dec_valid),
    .dec_format(dec_format),
    .dec_fail(dec_fail),
    .dec_sectors(dec_sectors),
    .dec_max_bytes(dec_max_bytes),
    .dec_ext48(dec_ext48),
    .tf_req(tf_req),
    .tf_write(tf_write),
    .tf_index(tf_index),
    .tf_wdata(tf_wdata),
    .tf_ack(tf_ack),
    .tf_rdata(tf_rdata),
    .tf_read_bytes(tf_read_bytes)
  );
  acbd_tf_model u_tf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .slow(slow),
    .tf_req(tf_req),
    .tf_write(tf_write),
    .tf_index(tf_index),
    .tf_ack(tf_ack),
    .tf_rdata(tf_rdata)
  );
  task report_and_stop;
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] want);
    n_compared++;
    if (got !== want) begin
      err_count++;
      $display("Error at %0t: got %0h want %0h", $time, got, want);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task mk(input logic [7:0] act, input logic [7:0] sel, input logic [7:0] c);
    b = 128'h0;
    b[15:0] = {V1_SIG_RESET[7:0], V1_SIG_RESET[15:8]};
    b[39:16] = {c, sel, act};
    b[103:40] = 64'h8877_6655_4433_2211;
  endtask
  task send(input logic [4:0] len);
    @(posedge core_clk);
    cb_bytes <= b;
    cb_length <= len;
    cb_valid <= 1'b1;
    do @(posedge core_clk); while (!cb_ready);
    cb_valid <= 1'b0;
    do @(posedge core_clk); while (!dec_valid);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    axi_rd(ADDR_CTRL);
    chk(rd, CTRL_RESET);
    axi_rd(ADDR_V2_SIG);
    chk(rd, {16'h0000, V2_SIG_RESET});
    axi_rd(8'h40);
    chk(rs, RESP_SLVERR);
    axi_wr(ADDR_V2_SIG, {16'h0000, V2_SIG_RESET});
    chk(rs, RESP_OKAY);
    axi_wr(8'h40, 32'h0);
    chk(rs, RESP_SLVERR);
    for (int i = 0; i < 11; i++) begin
      cnt = (i == 0) ? 8'h00 : (i > 8) ? 8'h03 + 8'(i) : 8'h01 << (i - 1);
      mk(8'h00, 8'h00, cnt);
      send(5'h10);
      chk(dec_fail, i > 8);
      chk(dec_format, FMT_V1);
      if (i < 9) chk(dec_sectors, (i == 0) ? 9'h100 : {1'b0, cnt});
    end
    slow <= 1'b1;
    mk(8'h01, 8'hA5, 8'h01);
    send(5'h10);
    exp = 64'h0;
    for (int i = 0; i < 8; i++) exp[8*i +: 8] = b[24+i] ? 8'hA0 + 8'(i) : 8'h00;
    chk(tf_read_bytes, exp);
    axi_rd(ADDR_TF_RD_HI);
    chk(rd, exp[63:32]);
    slow <= 1'b0;
    mk(8'h00, 8'h5A, 8'h80);
    send(5'h10);
    chk(dec_fail, 1'b0);
    b[15:0] = {V2_SIG_RESET[7:0], V2_SIG_RESET[15:8]};
    send(5'h10);
    chk(dec_format, FMT_V2);
    chk(dec_ext48, 1'b1);
    send(5'h0F);
    chk(dec_fail, 1'b1);
    b[15:0] = 16'h0000;
    send(5'h10);
    chk(dec_format, FMT_OTHER);
    axi_wr(ADDR_CTRL, 32'h0);
    axi_rd(ADDR_CTRL);
    chk(rd, 64'h0);
    mk(8'h00, 8'h00, 8'h01);
    send(5'h10);
    chk(dec_fail, 1'b1);
    axi_rd(ADDR_STATUS);
    chk(rd, (64'h11 << ST_CNT_LSB) | (64'h1 << ST_SECT_LSB) | (64'h1 << ST_FAIL_BIT) | (64'(FMT_V1) << ST_FMT_LSB));
    axi_wr(ADDR_CTRL, CTRL_RESET);
    report_and_stop;
  end
endmodule // tb
